// *** logic/adc_proc.sv ***
/*
  Dual-channel sample processing: serial register writes, dc removal, shared
  fine gain trim, decimating filter and a low-latency bypass path.
  Assumes samples arrive every cycle of clk_sys, the sample clock, and that
  the serial pins are already synchronous to it.
*/
module adc_proc #(
  parameter int SAMPLE_W = adc_proc_pkg::SAMPLE_W_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_port_clock,
  input wire logic serial_port_input,
  input wire logic serial_port_select_n,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  output logic [SAMPLE_W-1:0] out_a,
  output logic [SAMPLE_W-1:0] out_b,
  output logic out_valid
);
  import adc_proc_pkg::*;

  localparam int AW = SAMPLE_W + 30;
  localparam int DW = 2 * SAMPLE_W + 1;

  typedef struct packed {
    logic [15:0] shreg;
    logic [4:0] bitcnt;
    logic sclk_q;
    logic lowlat;
    logic [2:0] tc;
    logic [3:0] trim;
    logic dc_en;
    logic tap_user;
    logic fir_on;
    logic odd;
    logic [2:0] dec;
    logic [1:0] band;
    logic trim_written;
    logic [4:0] age;
    logic [AW-1:0] acc_a;
    logic [AW-1:0] acc_b;
    logic [SAMPLE_W-1:0] in_a;
    logic [SAMPLE_W-1:0] in_b;
    logic [SAMPLE_W-1:0] g_a;
    logic [SAMPLE_W-1:0] g_b;
    logic [4*SAMPLE_W-1:0] win_a;
    logic [4*SAMPLE_W-1:0] win_b;
    logic [2:0] phase;
    logic [SAMPLE_W-1:0] f_a;
    logic [SAMPLE_W-1:0] f_b;
    logic f_v;
    logic [SAMPLE_W-1:0] out_a;
    logic [SAMPLE_W-1:0] out_b;
    logic out_v;
  } state_s;

  state_s s;
  state_s next_s;
  logic [DW-1:0] fast_d;
  logic [DW-1:0] proc_d;

  // ******************************************************
  // helper functions
  // ******************************************************
  function automatic logic [SAMPLE_W-1:0] sat(input logic signed [31:0] v);
    logic signed [31:0] hi;
    logic signed [31:0] lo;
    hi = (32'sh1 <<< (SAMPLE_W - 1)) - 32'sh1;
    lo = -(32'sh1 <<< (SAMPLE_W - 1));
    if (v > hi) begin
      return hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      return lo[SAMPLE_W-1:0];
    end
    return v[SAMPLE_W-1:0];
  endfunction

  // q2.14 scale, 10^(code*0.05/20); unused codes fall back to unity
  function automatic logic [15:0] gain_q14(input logic [3:0] code);
    case (code)
      4'h1: return 16'h405f;
      4'h2: return 16'h40be;
      4'h3: return 16'h411d;
      4'h4: return 16'h417e;
      4'h5: return 16'h41de;
      4'h6: return 16'h4240;
      4'h7: return 16'h42a2;
      4'h8: return 16'h4304;
      4'h9: return 16'h4367;
      4'ha: return 16'h43cb;
      default: return 16'h4000;
    endcase
  endfunction

  function automatic logic [4:0] tc_log2(input logic [2:0] code);
    case (code)
      3'h1: return TC_LOG2_C1;
      3'h2: return TC_LOG2_C2;
      3'h3: return TC_LOG2_C3;
      3'h4: return TC_LOG2_C4;
      3'h5: return TC_LOG2_C5;
      default: return TC_LOG2_DEFAULT;
    endcase
  endfunction

  // samples per output minus one
  function automatic logic [2:0] dec_last(input logic [2:0] code);
    case (code)
      DEC_BY2: return 3'h1;
      DEC_BY4: return 3'h3;
      DEC_BY8: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  // dc removal then trim for one channel; returns {next accumulator, result}
  function automatic logic [AW+SAMPLE_W-1:0] dc_gain(
    input logic [SAMPLE_W-1:0] x,
    input logic [AW-1:0] acc,
    input logic en,
    input logic [2:0] tc,
    input logic [3:0] trim
  );
    logic signed [AW-1:0] est;
    logic signed [AW-1:0] nacc;
    logic signed [SAMPLE_W:0] corr;
    logic signed [SAMPLE_W+17:0] prod;
    est = en ? ($signed(acc) >>> tc_log2(tc)) : '0;
    nacc = en ? ($signed(acc) + AW'($signed(x)) - est) : '0;
    corr = $signed({x[SAMPLE_W-1], x}) - $signed(est[SAMPLE_W:0]);
    prod = corr * $signed({1'b0, gain_q14(trim)});
    return {nacc, sat(32'(prod >>> GAIN_FRAC))};
  endfunction

  // short built-in kernels; user taps are not held here, so they pass through
  function automatic logic [SAMPLE_W-1:0] fir_out(
    input logic [4*SAMPLE_W-1:0] win,
    input logic [2:0] dec,
    input logic [1:0] band,
    input logic user,
    input logic odd
  );
    logic [3:0] use_t;
    logic [3:0] neg_t;
    int sh;
    logic signed [SAMPLE_W+2:0] acc;
    logic [SAMPLE_W-1:0] x;
    use_t = 4'h1;
    neg_t = 4'h0;
    sh = 0;
    acc = '0;
    x = '0;
    if (!user) begin
      case (dec)
        DEC_BY2: begin
          use_t = 4'h3;
          neg_t = (band == BAND_HIGH2) ? 4'h2 : 4'h0;
          sh = 1;
        end
        DEC_BY4: begin
          use_t = 4'hf;
          case (band)
            2'h0: neg_t = 4'h0;
            2'h1: neg_t = 4'h6;
            2'h2: neg_t = 4'hc;
            default: neg_t = 4'ha;
          endcase
          sh = 2;
        end
        default: use_t = 4'h1;
      endcase
    end
    if (odd && use_t == 4'hf) begin
      use_t[3] = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      x = win[i*SAMPLE_W +: SAMPLE_W];
      if (use_t[i]) begin
        acc = neg_t[i] ? acc - $signed({{3{x[SAMPLE_W-1]}}, x})
                       : acc + $signed({{3{x[SAMPLE_W-1]}}, x});
      end
    end
    return sat(32'(acc >>> sh));
  endfunction

  // ******************************************************
  // latency padding
  // ******************************************************
  sample_delay #(.W(DW), .D(LAT_FAST - 1)) u_fast (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({1'b1, sample_a, sample_b}),
    .dout(fast_d)
  );

  sample_delay #(.W(DW), .D(LAT_NORMAL - PROC_STAGES - 1)) u_proc (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({s.f_v, s.f_a, s.f_b}),
    .dout(proc_d)
  );

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    logic [15:0] frame;
    logic wr;
    logic [AW+SAMPLE_W-1:0] ra;
    logic [AW+SAMPLE_W-1:0] rb;
    logic [4*SAMPLE_W-1:0] nwa;
    logic [4*SAMPLE_W-1:0] nwb;
    logic filt;
    next_s = s;
    frame = {s.shreg[14:0], serial_port_input};
    wr = 1'b0;
    ra = '0;
    rb = '0;
    nwa = '0;
    nwb = '0;
    filt = s.fir_on && !s.lowlat;
    next_s.sclk_q = serial_port_clock;
    // serial frame: 8 address bits then 8 data bits, msb first
    if (serial_port_select_n) begin
      next_s.bitcnt = '0;
    end else if (serial_port_clock && !s.sclk_q && s.bitcnt != FRAME_BITS) begin
      next_s.shreg = frame;
      next_s.bitcnt = s.bitcnt + 5'h1;
      wr = (s.bitcnt == FRAME_BITS - 5'h1);
    end
    next_s.age = (s.age == 5'h1f) ? s.age : s.age + 5'h1;
    if (wr) begin
      case (frame[15:8])
        ADDR_TRIM_CTRL: begin
          next_s.lowlat = frame[LOWLAT_BIT];
          next_s.tc = frame[TC_LSB +: 3];
          next_s.trim = frame[TRIM_LSB +: 4];
          next_s.trim_written = 1'b1;
          next_s.age = '0;
        end
        ADDR_FILT_CTRL: begin
          next_s.dc_en = frame[DC_EN_BIT];
          next_s.tap_user = frame[TAP_SRC_BIT];
          next_s.fir_on = frame[FIR_ON_BIT];
          next_s.odd = frame[ODD_BIT];
          next_s.dec = frame[DEC_LSB +: 3];
          next_s.age = '0;
        end
        ADDR_BAND_SEL: begin
          next_s.band = frame[BAND_LSB +: 2];
          next_s.age = '0;
        end
        default: next_s.age = s.age;
      endcase
    end
    // stage 1 capture, stage 2 dc removal and trim
    next_s.in_a = sample_a;
    next_s.in_b = sample_b;
    ra = dc_gain(s.in_a, s.acc_a, s.dc_en, s.tc, s.trim);
    rb = dc_gain(s.in_b, s.acc_b, s.dc_en, s.tc, s.trim);
    next_s.acc_a = ra[AW+SAMPLE_W-1:SAMPLE_W];
    next_s.acc_b = rb[AW+SAMPLE_W-1:SAMPLE_W];
    next_s.g_a = ra[SAMPLE_W-1:0];
    next_s.g_b = rb[SAMPLE_W-1:0];
    // stage 3 filter and decimation
    nwa = {s.win_a[3*SAMPLE_W-1:0], s.g_a};
    nwb = {s.win_b[3*SAMPLE_W-1:0], s.g_b};
    next_s.win_a = nwa;
    next_s.win_b = nwb;
    if (filt) begin
      next_s.phase = (s.phase >= dec_last(s.dec)) ? 3'h0 : s.phase + 3'h1;
      next_s.f_v = (s.phase >= dec_last(s.dec));
      next_s.f_a = fir_out(nwa, s.dec, s.band, s.tap_user, s.odd);
      next_s.f_b = fir_out(nwb, s.dec, s.band, s.tap_user, s.odd);
    end else begin
      next_s.phase = '0;
      next_s.f_v = 1'b1;
      next_s.f_a = s.g_a;
      next_s.f_b = s.g_b;
    end
    // output select; the fast path skips every processing stage
    if (s.lowlat) begin
      {next_s.out_v, next_s.out_a, next_s.out_b} = fast_d;
    end else begin
      {next_s.out_v, next_s.out_a, next_s.out_b} = proc_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_a = s.out_a;
  assign out_b = s.out_b;
  assign out_valid = s.out_v;

  // ******************************************************
  // checks
  // ******************************************************
  a_trim_reset: assert property (@(posedge clk_sys) disable iff (rst)
    !s.trim_written |-> s.trim == TRIM_RST)
    else $error("trim left its reset code without a write");

  a_trim_step: assert property (@(posedge clk_sys) disable iff (rst)
    (s.trim == TRIM_MAX && !s.dc_en && s.in_a == 12'h3e8) |=> s.g_a == 12'h423)
    else $error("top trim code does not give +0.5 dB");

  a_trim_shared: assert property (@(posedge clk_sys) disable iff (rst)
    (s.in_a == s.in_b && s.acc_a == s.acc_b) |=> s.g_a == s.g_b)
    else $error("channels trimmed differently");

  a_normal_latency: assert property (@(posedge clk_sys) disable iff (rst)
    (s.age >= 5'h14 && !s.lowlat && !s.fir_on && !s.dc_en && s.trim == 4'h0)
    |-> (out_a == $past(sample_a, 14) && out_b == $past(sample_b, 14) && out_valid))
    else $error("normal path latency is not 14 cycles");

  a_fast_latency: assert property (@(posedge clk_sys) disable iff (rst)
    (s.age >= 5'h14 && s.lowlat)
    |-> (out_a == $past(sample_a, 10) && out_b == $past(sample_b, 10) && out_valid))
    else $error("fast path latency is not 10 cycles");

  a_dc_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !s.dc_en |=> s.acc_a == '0 && s.acc_b == '0)
    else $error("offset estimate runs while disabled");

  a_dec4_rate: assert property (@(posedge clk_sys) disable iff (rst)
    (s.age >= 5'h14 && s.age < 5'h1b && s.fir_on && !s.lowlat && s.dec == DEC_BY4 && s.f_v)
    |=> !s.f_v [*3] ##1 s.f_v)
    else $error("decimate by 4 spacing wrong");

  a_nodec_rate: assert property (@(posedge clk_sys) disable iff (rst)
    (s.fir_on && !s.lowlat && s.dec == DEC_NONE) |=> s.f_v && s.f_a == $past(s.g_a))
    else $error("no-decimation mode dropped or altered a sample");

  a_filter_off: assert property (@(posedge clk_sys) disable iff (rst)
    !s.fir_on |=> s.f_v && s.f_a == $past(s.g_a) && s.f_b == $past(s.g_b))
    else $error("filter not bypassed");

  a_user_taps: assert property (@(posedge clk_sys) disable iff (rst)
    (s.fir_on && !s.lowlat && s.tap_user) |=> s.f_a == $past(s.g_a))
    else $error("built-in kernel used with user taps selected");
endmodule

// *** logic/adc_proc_pkg.sv ***
/*
  Constants shared by the sample processing block: serial register map, field
  positions, reset values, mode codes and pipeline latencies.
  Assumes the sample clock is the single clock of the block.
*/
package adc_proc_pkg;
  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [7:0] ADDR_TRIM_CTRL = 8'h1a;
  localparam logic [7:0] ADDR_FILT_CTRL = 8'h1b;
  localparam logic [7:0] ADDR_BAND_SEL = 8'h1d;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // ******************************************************
  // field positions
  // ******************************************************
  localparam int LOWLAT_BIT = 7;
  localparam int TC_LSB = 4;
  localparam int TRIM_LSB = 0;
  localparam int DC_EN_BIT = 7;
  localparam int TAP_SRC_BIT = 5;
  localparam int FIR_ON_BIT = 4;
  localparam int ODD_BIT = 3;
  localparam int DEC_LSB = 0;
  localparam int BAND_LSB = 0;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [3:0] TRIM_RST = 4'h0;
  localparam logic [2:0] TC_RST = 3'h0;
  localparam logic [2:0] DEC_RST = 3'h0;
  localparam logic [1:0] BAND_RST = 2'h0;

  // ******************************************************
  // mode codes
  // ******************************************************
  localparam logic [2:0] DEC_BY2 = 3'h0;
  localparam logic [2:0] DEC_BY4 = 3'h1;
  localparam logic [2:0] DEC_NONE = 3'h3;
  localparam logic [2:0] DEC_BY8 = 3'h4;
  localparam logic [1:0] BAND_HIGH2 = 2'h1;
  localparam logic [3:0] TRIM_MAX = 4'ha;

  // dc removal averaging length as a power of two
  localparam logic [4:0] TC_LOG2_DEFAULT = 5'h1b;
  localparam logic [4:0] TC_LOG2_C1 = 5'h1a;
  localparam logic [4:0] TC_LOG2_C2 = 5'h19;
  localparam logic [4:0] TC_LOG2_C3 = 5'h18;
  localparam logic [4:0] TC_LOG2_C4 = 5'h1c;
  localparam logic [4:0] TC_LOG2_C5 = 5'h1d;

  // ******************************************************
  // timing in sample clock cycles, plus gain fraction bits and default sample width
  // ******************************************************
  localparam int LAT_NORMAL = 14;
  localparam int LAT_FAST = 10;
  localparam int PROC_STAGES = 3;
  localparam int GAIN_FRAC = 14;
  localparam int SAMPLE_W_DEF = 12;
endpackage

// *** logic/sample_delay.sv ***
/*
  Fixed-length delay line for a word of samples.
  Assumes one word enters every clock; output comes from the last register.
*/
module sample_delay #(
  parameter int W = 25,
  parameter int D = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [D-1:0][W-1:0] line;
  } delay_s;

  delay_s s;
  delay_s next_s;

  always_comb begin
    next_s = s;
    next_s.line[0] = din;
    for (int i = 1; i < D; i++) begin
      next_s.line[i] = s.line[i-1];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.line[D-1];
endmodule

// *** tb/host_serial_port.sv ***
/*
  Host model for the serial register port: writes one 16-bit frame per call.
  Assumes the port samples its pins on clk_sys and needs each serial clock
  phase to last at least one clk_sys cycle.
*/
module host_serial_port (
  input wire logic clk_sys,
  output logic serial_port_clock,
  output logic serial_port_input,
  output logic serial_port_select_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ******************************************************
  // idle levels
  // ******************************************************
  // idle levels follow the pin pulls: clock and data low, select high
  initial begin
    serial_port_clock = 1'b0;
    serial_port_input = 1'b0;
    serial_port_select_n = 1'b1;
  end

  // ******************************************************
  // frame writer
  // ******************************************************
  // clock phases of two cycles each, margin over the one-cycle minimum
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [15:0] frame;
    frame = {addr, data};
    @(posedge clk_sys);
    serial_port_select_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys);
      serial_port_clock <= 1'b1;
      serial_port_input <= frame[i];
      repeat (2) @(posedge clk_sys);
      serial_port_clock <= 1'b0;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    serial_port_select_n <= 1'b1;
    serial_port_input <= 1'b0;
  endtask
endmodule

// *** tb/testbench.sv ***
/*
  Self-checking bench for the sample processing block: register writes over
  the serial port, then latency, trim, filter and decimation checks.
  Assumes the host model drives only the 8+8 write frame of the register map.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_proc_pkg::*;

  logic clk_sys;
  logic rst;
  wire serial_port_clock;
  wire serial_port_input;
  wire serial_port_select_n;
  logic [11:0] sample_a;
  logic [11:0] sample_b;
  logic [11:0] out_a;
  logic [11:0] out_b;
  logic out_valid;
  logic [11:0] const_a;
  logic [11:0] const_b;
  logic ramp;
  int cyc = 0;
  int err_count;
  int n_compared;

  adc_proc #(.SAMPLE_W(12)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .serial_port_clock(serial_port_clock),
    .serial_port_input(serial_port_input),
    .serial_port_select_n(serial_port_select_n),
    .sample_a(sample_a),
    .sample_b(sample_b),
    .out_a(out_a),
    .out_b(out_b),
    .out_valid(out_valid)
  );

  host_serial_port host (
    .clk_sys(clk_sys),
    .serial_port_clock(serial_port_clock),
    .serial_port_input(serial_port_input),
    .serial_port_select_n(serial_port_select_n)
  );

  // ******************************************************
  // clock and sample source
  // ******************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [11:0] ramp_val(input int m);
    return 12'(m % 1024);
  endfunction

  // ramp gives each cycle a distinct word, so latency is read off exactly
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sample_a <= ramp ? ramp_val(cyc + 1) : const_a;
    sample_b <= ramp ? (12'h800 | ramp_val(cyc + 1)) : const_b;
  end

  // ******************************************************
  // compare tasks
  // ******************************************************
  task automatic check_word(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_count(input string name, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ******************************************************
  // scenario helpers
  // ******************************************************
  // mode switches corrupt up to ~14 words, so let the pipe flush first
  task automatic settle;
    repeat (24) @(posedge clk_sys);
  endtask

  task automatic check_latency(input int lat);
    settle();
    repeat (6) begin
      @(negedge clk_sys);
      check_word("out_a latency", ramp_val(cyc - lat), out_a);
      check_word("out_b latency", 12'h800 | ramp_val(cyc - lat), out_b);
    end
  endtask

  task automatic run_mode(input logic [7:0] filt, input logic [7:0] band,
                          input logic [11:0] ea, input logic [11:0] eb, input int nvalid);
    int seen;
    seen = 0;
    host.write_reg(ADDR_BAND_SEL, band);
    host.write_reg(ADDR_FILT_CTRL, filt);
    settle();
    repeat (32) begin
      @(negedge clk_sys);
      if (out_valid === 1'b1) begin
        seen++;
        check_word("out_a", ea, out_a);
        check_word("out_b", eb, out_b);
      end
    end
    check_count("out_valid count", nvalid, seen);
  endtask

  // ******************************************************
  // main sequence
  // ******************************************************
  logic [7:0] t_filt [9] = '{8'h10, 8'h10, 8'h11, 8'h11, 8'h11, 8'h11, 8'h34, 8'h33, 8'h30};
  logic [7:0] t_band [9] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00};
  logic [11:0] t_a [9] = '{12'h064, 12'h000, 12'h064, 12'h000, 12'h000, 12'h000,
                           12'h064, 12'h064, 12'h064};
  logic [11:0] t_b [9] = '{12'hf9c, 12'h000, 12'hf9c, 12'h000, 12'h000, 12'h000,
                           12'hf9c, 12'hf9c, 12'hf9c};
  int t_n [9] = '{16, 16, 8, 8, 8, 8, 4, 32, 16};

  initial begin
    rst = 1'b1;
    ramp = 1'b1;
    const_a = 12'h000;
    const_b = 12'h000;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    check_latency(LAT_NORMAL);
    const_a <= 12'h3e8;
    const_b <= 12'hc18;
    ramp <= 1'b0;
    host.write_reg(ADDR_TRIM_CTRL, 8'h01);
    run_mode(8'h00, 8'h00, 12'h3ed, 12'hc12, 32);
    host.write_reg(ADDR_TRIM_CTRL, {4'h0, TRIM_MAX});
    run_mode(8'h00, 8'h01, 12'h423, 12'hbdc, 32);
    host.write_reg(ADDR_TRIM_CTRL, 8'h00);
    const_a <= 12'h064;
    const_b <= 12'hf9c;
    for (int i = 0; i < 9; i++) begin
      run_mode(t_filt[i], t_band[i], t_a[i], t_b[i], t_n[i]);
    end
    run_mode(8'h19, 8'h00, 12'h04b, 12'hfb5, 8);
    // shortest averaging and a full-scale input: the estimate reaches one
    // lsb after about 8200 samples, so the offset becomes visible in the run
    host.write_reg(ADDR_TRIM_CTRL, 8'h30);
    const_a <= 12'h7ff;
    const_b <= 12'h7ff;
    run_mode(8'h80, 8'h00, 12'h7ff, 12'h7ff, 32);
    repeat (8300) @(posedge clk_sys);
    run_mode(8'h80, 8'h00, 12'h7fe, 12'h7fe, 32);
    // fast path with maximum trim and a zeroing band: all must be bypassed
    host.write_reg(ADDR_FILT_CTRL, 8'h11);
    host.write_reg(ADDR_BAND_SEL, 8'h03);
    host.write_reg(ADDR_TRIM_CTRL, 8'h8a);
    ramp <= 1'b1;
    check_latency(LAT_FAST);
    // second reset mid-run must restore the normal path
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    check_latency(LAT_NORMAL);
    complete_run();
  end

  // ******************************************************
  // watchdog
  // ******************************************************
  // the sequence needs about 12000 cycles; five times that is a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end
endmodule
